// ### core/module_gate_defs.vh
// Register offsets, field positions and reset values of the peripheral gate bank
`ifndef MODULE_GATE_DEFS_VH
`define MODULE_GATE_DEFS_VH

// Byte offsets of the three gate registers
`define SERIAL_PERIPH3_GATE_OFS 12'h000
`define DMA_CONTROLLERS_GATE_OFS 12'h004
`define UART_LOGIC_CELL_GATE_OFS 12'h008

// Field positions
`define THIRD_SPI_BIT 0
`define LOWER_DMA_BIT 4
`define UPPER_DMA_BIT 5
`define LOGIC_CELL1_BIT 2
`define LOGIC_CELL4_BIT 5
`define FIFTH_UART_BIT 6
`define SIXTH_UART_BIT 7

// Implemented-bit masks per register
`define SERIAL_PERIPH3_MASK 16'h0001
`define DMA_CONTROLLERS_MASK 16'h0030
`define UART_LOGIC_CELL_MASK 16'h00FC

// Reset values
`define GATE_RESET_16 16'h0000
`define RDATA_RESET 32'h0000_0000

`endif

// ### core/peripheral_module_disable_bank.v
// Peripheral power and clock gate register bank with an APB slave
//
// Behaviour
// - Bit 0 of the first gate register disables the third SPI unit when one, enables it when zero.
// - Bits 15 to 1 of the first gate register read zero and ignore writes.
// - Bit 5 of the second gate register disables the upper DMA controller (channels 4 to 7).
// - Bit 4 of the second gate register disables the lower DMA controller (channels 0 to 3).
// - Bits 15 to 6 and 3 to 0 of the second gate register read zero and ignore writes.
// - The third gate register holds six gate bits 7 to 2 and reads zero in bits 15-8 and 1-0.
// - Each gate bit of the third register disables its UART or logic cell when one.
`timescale 1ns/1ns
`include "module_gate_defs.vh"

module peripheral_module_disable_bank (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB request
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   // APB answer
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Per-module disable levels, high disables
   output reg third_spi_gate_bit,
   output reg lower_dma_ctrl_gate_bit,
   output reg upper_dma_ctrl_gate_bit,
   output reg [4:1] logic_cell_gate_bits,
   output reg fifth_uart_gate_bit,
   output reg sixth_uart_gate_bit
);

   reg [15:0] serial_periph3_gate_reg_q;
   reg [15:0] dma_controllers_gate_reg_q;
   reg [15:0] uart_logic_cell_gate_reg_q;
   reg [15:0] serial_periph3_gate_reg_d;
   reg [15:0] dma_controllers_gate_reg_d;
   reg [15:0] uart_logic_cell_gate_reg_d;
   reg pready_q;
   reg pslverr_q;
   reg [31:0] rdata_d;
   wire access;
   wire wr_en;
   wire rd_en;
   wire hit;

   // Merge a write into the implemented bits only, honouring byte strobes
   function [15:0] merge;
      input [15:0] old;
      input [31:0] wdata;
      input [3:0] strb;
      input [15:0] mask;
      reg [15:0] lanes;
      begin
         lanes = {{8{strb[1]}}, {8{strb[0]}}};
         merge = ((old & ~lanes) | (wdata[15:0] & lanes)) & mask;
      end
   endfunction

   // Address decode
   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = (a == `SERIAL_PERIPH3_GATE_OFS) || (a == `DMA_CONTROLLERS_GATE_OFS)
            || (a == `UART_LOGIC_CELL_GATE_OFS);
      end
   endfunction

   // Answer one cycle into the access phase
   assign access = psel & penable & ~pready_q;
   assign hit = is_mapped(paddr);
   assign wr_en = access & pwrite & hit;
   assign rd_en = access & ~pwrite;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // Next register values
   always @* begin
      serial_periph3_gate_reg_d = serial_periph3_gate_reg_q;
      dma_controllers_gate_reg_d = dma_controllers_gate_reg_q;
      uart_logic_cell_gate_reg_d = uart_logic_cell_gate_reg_q;
      if (wr_en && paddr == `SERIAL_PERIPH3_GATE_OFS) begin
         serial_periph3_gate_reg_d = merge(serial_periph3_gate_reg_q, pwdata, pstrb,
            `SERIAL_PERIPH3_MASK);
      end
      if (wr_en && paddr == `DMA_CONTROLLERS_GATE_OFS) begin
         dma_controllers_gate_reg_d = merge(dma_controllers_gate_reg_q, pwdata, pstrb,
            `DMA_CONTROLLERS_MASK);
      end
      if (wr_en && paddr == `UART_LOGIC_CELL_GATE_OFS) begin
         uart_logic_cell_gate_reg_d = merge(uart_logic_cell_gate_reg_q, pwdata, pstrb,
            `UART_LOGIC_CELL_MASK);
      end
   end

   // Read mux, unmapped reads return zero
   always @* begin
      rdata_d = `RDATA_RESET;
      case (paddr)
         `SERIAL_PERIPH3_GATE_OFS: rdata_d = {16'h0000, serial_periph3_gate_reg_q};
         `DMA_CONTROLLERS_GATE_OFS: rdata_d = {16'h0000, dma_controllers_gate_reg_q};
         `UART_LOGIC_CELL_GATE_OFS: rdata_d = {16'h0000, uart_logic_cell_gate_reg_q};
         default: rdata_d = `RDATA_RESET;
      endcase
   end

   // Registers, bus answer and gate outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_periph3_gate_reg_q <= `GATE_RESET_16;
         dma_controllers_gate_reg_q <= `GATE_RESET_16;
         uart_logic_cell_gate_reg_q <= `GATE_RESET_16;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata <= `RDATA_RESET;
         third_spi_gate_bit <= 1'b0;
         lower_dma_ctrl_gate_bit <= 1'b0;
         upper_dma_ctrl_gate_bit <= 1'b0;
         logic_cell_gate_bits <= 4'h0;
         fifth_uart_gate_bit <= 1'b0;
         sixth_uart_gate_bit <= 1'b0;
      end else begin
         serial_periph3_gate_reg_q <= serial_periph3_gate_reg_d;
         dma_controllers_gate_reg_q <= dma_controllers_gate_reg_d;
         uart_logic_cell_gate_reg_q <= uart_logic_cell_gate_reg_d;
         pready_q <= access;
         pslverr_q <= access & ~hit;
         if (rd_en) begin
            prdata <= rdata_d;
         end
         // Gate levels follow the registers with the same timing as the register
         third_spi_gate_bit <= serial_periph3_gate_reg_d[`THIRD_SPI_BIT];
         upper_dma_ctrl_gate_bit <= dma_controllers_gate_reg_d[`UPPER_DMA_BIT];
         lower_dma_ctrl_gate_bit <= dma_controllers_gate_reg_d[`LOWER_DMA_BIT];
         logic_cell_gate_bits <=
            uart_logic_cell_gate_reg_d[`LOGIC_CELL4_BIT:`LOGIC_CELL1_BIT];
         fifth_uart_gate_bit <= uart_logic_cell_gate_reg_d[`FIFTH_UART_BIT];
         sixth_uart_gate_bit <= uart_logic_cell_gate_reg_d[`SIXTH_UART_BIT];
      end
   end

endmodule // peripheral_module_disable_bank

// ### tb/gate_bank_sva.sv
// Assertion checker for the peripheral gate register bank
`timescale 1ns/1ns
module gate_bank_chk (
   // Clock and reset
   input wire logic pclk, input wire logic presetn,
   // APB
   input wire logic psel, input wire logic penable, input wire logic pwrite,
   input wire logic [11:0] paddr, input wire logic [31:0] pwdata, input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata, input wire logic pready, input wire logic pslverr,
   // Gates
   input wire logic third_spi_gate_bit, input wire logic lower_dma_ctrl_gate_bit,
   input wire logic upper_dma_ctrl_gate_bit, input wire logic [4:1] logic_cell_gate_bits,
   input wire logic fifth_uart_gate_bit, input wire logic sixth_uart_gate_bit
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed mapped transfers and gate groups
   wire wr = psel && penable && pready && pwrite && !pslverr;
   wire rd = psel && penable && pready && !pwrite && !pslverr;
   wire [5:0] cl = {sixth_uart_gate_bit, fifth_uart_gate_bit, logic_cell_gate_bits};
   wire [8:0] g = {cl, upper_dma_ctrl_gate_bit, lower_dma_ctrl_gate_bit, third_spi_gate_bit};
   a_spi_wr: assert property (wr && paddr == 12'h000 && pstrb[0] |-> g[0] == pwdata[0])
      else $error("third spi gate not written");
   a_dma_wr: assert property (wr && paddr == 12'h004 && pstrb[0] |-> g[2:1] == pwdata[5:4])
      else $error("dma gates not written");
   a_cell_wr: assert property (wr && paddr == 12'h008 && pstrb[0] |-> cl == pwdata[7:2])
      else $error("uart and cell gates not written");
   a_spi_rd: assert property (rd && paddr == 12'h000 |-> prdata == {31'h0, g[0]})
      else $error("spi register readback wrong");
   a_dma_rd: assert property (rd && paddr == 12'h004 |-> prdata == {26'h0, g[2:1], 4'h0})
      else $error("dma register readback wrong");
   a_cell_rd: assert property (rd && paddr == 12'h008 |-> prdata == {24'h0, cl, 2'h0})
      else $error("uart and cell readback wrong");
   a_gate_hold: assert property (!$stable(g) |-> $past(psel && penable && pwrite))
      else $error("gate changed without a write");
   a_reset_clr: assert property (@(posedge pclk) disable iff (1'b0) !presetn |-> g == 9'h000)
      else $error("gates not cleared in reset");
   a_unmapped_err: assert property (psel && penable && pready |->
      pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008))
      else $error("error response on wrong address");
endmodule // gate_bank_chk
bind peripheral_module_disable_bank gate_bank_chk chk_i (.*);

// ### tb/testbench.sv
// Self-checking testbench for the peripheral gate register bank
`timescale 1ns/1ns
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
   // Stimulus and observed ports
   logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0] pstrb = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, third_spi_gate_bit, lower_dma_ctrl_gate_bit, upper_dma_ctrl_gate_bit;
   wire fifth_uart_gate_bit, sixth_uart_gate_bit;
   wire [4:1] logic_cell_gate_bits;
   int bad_count = 0, compares = 0;
   // Rows: address, strobes, write data, expected readback
   logic [63:0] rows [8] = '{64'h000F_FFFFFFFF_0001, 64'h004F_FFFFFFFF_0030,
      64'h008F_FFFFFFFF_00FC, 64'h000F_FFFFFFFE_0000, 64'h004F_0000FFDF_0010,
      64'h008F_00000054_0054, 64'h008E_000000FF_0054, 64'h00CF_FFFFFFFF_0000};
   peripheral_module_disable_bank peripheral_module_disable_bank_i (.*);
   initial forever #25 pclk = ~pclk;
   // One APB transfer, held until pready is sampled high
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk); penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata; err = pslverr; psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task summarize;
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #100000; bad_count++; summarize;
   end
   // Table walk, then gate levels and a mid-run reset
   initial begin
      presetn <= 0;
      repeat (20) @(posedge pclk);
      presetn <= 1; @(posedge pclk);
      foreach (rows[i]) begin
         xfer(1, rows[i][63:52], rows[i][47:16], rows[i][51:48], rd);
         xfer(0, rows[i][63:52], 32'h0, 4'hF, rd);
         `CHK(rd, {16'h0, rows[i][15:0]})
      end
      `CHK(err, 1'b1)
      `CHK({sixth_uart_gate_bit, fifth_uart_gate_bit, logic_cell_gate_bits, upper_dma_ctrl_gate_bit,
         lower_dma_ctrl_gate_bit, third_spi_gate_bit}, 9'h0AA)
      presetn <= 0; @(posedge pclk); presetn <= 1; @(posedge pclk);
      xfer(0, 12'h008, 32'h0, 4'hF, rd);
      `CHK({rd[7:2], lower_dma_ctrl_gate_bit}, 7'h00)
      summarize;
   end
endmodule // testbench
